// file: hdl/fse_pkg.sv
// Constants, types and carriers for the float status/exception unit.
// Assumes one clock domain; all event inputs come from the FPU datapath.
package fse_pkg;
    // Register byte addresses
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CODE = 4'h4;
    localparam logic [3:0] ADDR_ADDR = 4'h8;
    // Status bit positions
    localparam int B_ERR = 15;
    localparam int B_TDIS = 14;
    localparam int B_UV = 11;
    localparam int B_UNF = 10;
    localparam int B_OVF = 9;
    localparam int B_IC = 8;
    localparam int B_DBL = 7;
    localparam int B_LONG = 6;
    localparam int B_CHOP = 5;
    localparam int B_MAINT = 4;
    localparam int B_NEG = 3;
    localparam int B_ZERO = 2;
    localparam int B_VFLAG = 1;
    localparam int B_CARRY = 0;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [15:0] STATUS_WMASK = 16'hCFFF;
    // Exception codes
    localparam logic [3:0] EC_NONE = 4'h0;
    localparam logic [3:0] EC_OPCODE = 4'h2;
    localparam logic [3:0] EC_DIV0 = 4'h4;
    localparam logic [3:0] EC_ICONV = 4'h6;
    localparam logic [3:0] EC_OVF = 4'h8;
    localparam logic [3:0] EC_UNF = 4'hA;
    localparam logic [3:0] EC_UNDEF = 4'hC;
    localparam logic [3:0] EC_MAINT = 4'hE;
    // Shared trap vector, 244 octal
    localparam logic [15:0] TRAP_VECTOR = 16'h00A4;
    // Operand addressing
    localparam logic [2:0] MODE_DIRECT_AC = 3'h0;
    localparam logic [3:0] STEP_SINGLE = 4'h4;
    localparam logic [3:0] STEP_DOUBLE = 4'h8;
    localparam logic [2:0] AC_MEM_MASK = 3'h3;
    localparam int SHORT_INT_W = 16;
    localparam int LONG_INT_W = 32;
    localparam int CONV_W = 40;
    // Float word fields
    localparam int SIGN_BIT = 63;
    localparam int EXP_HI = 62;
    localparam int EXP_LO = 55;

    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_CMP, OP_MOD, OP_NEG, OP_ABS,
        OP_TST, OP_LOAD, OP_CONV, OP_OTHER
    } fse_op_t;

    typedef enum logic {
        PH_OPERAND, PH_DONE
    } fse_phase_t;

    // One report from the datapath per instruction phase
    typedef struct packed {
        logic valid;
        fse_phase_t phase;
        fse_op_t op;
        logic [15:0] instr_addr;
        logic [2:0] mode;
        logic [2:0] ac;
        logic op_sign;
        logic [7:0] op_exp;
        logic illegal_op;
        logic div_zero;
        logic maint_trap;
        logic overflow;
        logic underflow;
        logic carry;
        logic [63:0] result;
        logic signed [CONV_W-1:0] conv_int;
    } fse_evt_t;

    // Registered answer back to the datapath
    typedef struct packed {
        logic valid;
        logic abort;
        logic [63:0] result;
        logic [2:0] ac_sel;
        logic [3:0] step;
        logic dbl;
        logic long_int;
        logic chop;
    } fse_ans_t;
endpackage

// file: hdl/fse_status_exc.sv
// Float status word, exception code/address and trap request logic.
// Assumes datapath reports arrive on clk_i; registers over Avalon-MM.
//
// Behaviour
// - Memory -0 operand of listed ops traps when undefined-operand trap enabled.
// - -0 trap before execution, except negate and absolute trap afterwards.
// - No -0 trap when disabled, or for accumulator operands in mode 0.
// - Enabled underflow traps, keeps fraction and wrapped low exponent bits.
// - Disabled underflow: no trap, result is exact zero.
// - Enabled overflow traps, keeps fraction with exponent wrapped low.
// - Disabled overflow: no trap, result is exact zero.
// - Failed integer conversion stores zero; traps only if enabled.
// - Conversion fails when integer exceeds selected short or long width.
// - Precision select bit chooses double or single arithmetic.
// - Long select bit chooses 32-bit or 16-bit integers.
// - Chop select bit truncates results, else rounds.
// - Maintenance bit can only be set in kernel mode.
// - Negative, zero and overflow flags follow each operation except a negate or absolute -0 trap.
// - Carry flag records conversion carry out of the top bit.
// - All floating exceptions use one trap vector, 244 octal.
// - Code register records cause; address register the faulting instruction.
// - Code and address update only on qualifying exceptions.
// - Global trap disable does not stop code and address recording.
// - Code and address registers are read-only to software.
// - Mode 0 reaches six accumulators, others four; step by 4 or 8.
// - Rounded equals chopped plus one LSB when first dropped bit set.
// - Global trap disable blocks every trap, other actions remain.
// - Error flag set on qualifying exceptions, cleared only by load or reset.
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module fse_status_exc #(
    parameter int FRAC_W = 56
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Host processor
    input wire logic cpu_kernel_i,
    input wire logic trap_ack_i,
    output logic trap_req_o,
    output logic [15:0] trap_vector_o,
    // Datapath reports and answers
    input wire fse_pkg::fse_evt_t evt_i,
    output fse_pkg::fse_ans_t ans_o,
    // Rounding helper
    input wire logic [FRAC_W-1:0] rnd_frac_i,
    input wire logic rnd_bit_i,
    input wire logic rnd_valid_i,
    output logic [FRAC_W-1:0] rnd_frac_o,
    output logic rnd_valid_o
);
    import fse_pkg::*;

    if (FRAC_W < 24 || FRAC_W > 64) begin : g_frac_check
        $error("FRAC_W out of range");
    end

    logic [15:0] status_q;
    logic [3:0] code_q;
    logic [15:0] eaddr_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic trap_q;

    // Operations that check memory operands for -0
    function automatic logic checks_minus0(input fse_op_t op);
        unique case (op)
            OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_CMP, OP_MOD, OP_NEG, OP_ABS,
            OP_TST, OP_LOAD: checks_minus0 = 1'b1;
            default: checks_minus0 = 1'b0;
        endcase
    endfunction

    function automatic logic late_trap(input fse_op_t op);
        late_trap = (op == OP_NEG) || (op == OP_ABS);
    endfunction

    // Signed value fits in w bits
    function automatic logic fits(input logic signed [CONV_W-1:0] v, input int w);
        logic signed [CONV_W-1:0] lim;
        lim = CONV_W'(1) <<< (w - 1);
        fits = (v < lim) && (v >= -lim);
    endfunction

    // Bus decode
    logic bus_req;
    logic wr_status;
    logic [31:0] rd_mux;
    assign bus_req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req & ~ack_q;
    assign wr_status = avs_write_i & ack_q & (avs_address_i == ADDR_STATUS);
    assign avs_readdata_o = rdata_q;

    always_comb begin
        unique case (avs_address_i)
            ADDR_STATUS: rd_mux = {16'h0000, status_q};
            ADDR_CODE: rd_mux = {28'h0000000, code_q};
            ADDR_ADDR: rd_mux = {16'h0000, eaddr_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // One wait state per access
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 32'h00000000;
        end else if (avs_read_i && !ack_q) begin
            rdata_q <= rd_mux;
        end
    end

    // Exception evaluation
    logic from_mem;
    logic minus0_hit;
    logic pre_trap;
    logic post_uv;
    logic conv_fail;
    logic ovf_en;
    logic unf_en;
    logic ic_en;
    logic uv_en;
    logic done;
    logic qualify;
    logic [3:0] cause;
    logic [63:0] res_word;
    logic res_zero;
    logic res_neg;

    assign uv_en = status_q[B_UV];
    assign ovf_en = status_q[B_OVF];
    assign unf_en = status_q[B_UNF];
    assign ic_en = status_q[B_IC];
    assign done = evt_i.valid && (evt_i.phase == PH_DONE);
    // Accumulator operands never count as -0 sources
    assign from_mem = (evt_i.mode != MODE_DIRECT_AC);
    assign minus0_hit = uv_en && from_mem && evt_i.op_sign && (evt_i.op_exp == 8'h00)
        && checks_minus0(evt_i.op);
    assign pre_trap = evt_i.valid && (evt_i.phase == PH_OPERAND) && minus0_hit
        && !late_trap(evt_i.op);
    assign post_uv = done && minus0_hit && late_trap(evt_i.op);
    assign conv_fail = (evt_i.op == OP_CONV) && (status_q[B_LONG]
        ? !fits(evt_i.conv_int, LONG_INT_W) : !fits(evt_i.conv_int, SHORT_INT_W));

    // Priority of causes within one report
    always_comb begin
        cause = EC_NONE;
        if (pre_trap || post_uv) begin
            cause = EC_UNDEF;
        end else if (done) begin
            if (evt_i.illegal_op) begin
                cause = EC_OPCODE;
            end else if (evt_i.div_zero) begin
                cause = EC_DIV0;
            end else if (conv_fail && ic_en) begin
                cause = EC_ICONV;
            end else if (evt_i.overflow && ovf_en) begin
                cause = EC_OVF;
            end else if (evt_i.underflow && unf_en) begin
                cause = EC_UNF;
            end else if (evt_i.maint_trap && status_q[B_MAINT]) begin
                cause = EC_MAINT;
            end
        end
    end
    assign qualify = (cause != EC_NONE);

    // Code and address: no software write path
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            code_q <= EC_NONE;
            eaddr_q <= 16'h0000;
        end else if (qualify) begin
            code_q <= cause;
            eaddr_q <= evt_i.instr_addr;
        end
    end

    // Status word
    logic [15:0] wr_val;
    always_comb begin
        wr_val = avs_writedata_i[15:0] & STATUS_WMASK;
        if (!cpu_kernel_i) begin
            wr_val[B_MAINT] = status_q[B_MAINT];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_q <= STATUS_RST;
        end else begin
            if (wr_status) begin
                status_q <= wr_val;
            end
            if (done && !post_uv) begin
                status_q[B_NEG] <= res_neg;
                status_q[B_ZERO] <= res_zero;
                status_q[B_VFLAG] <= evt_i.overflow;
                status_q[B_CARRY] <= (evt_i.op == OP_CONV) && evt_i.carry;
            end
            // Set wins over a simultaneous load
            if (qualify) begin
                status_q[B_ERR] <= 1'b1;
            end
        end
    end

    // Result fix-up
    always_comb begin
        res_word = evt_i.result;
        if (evt_i.underflow && !unf_en) begin
            res_word = 64'h0000000000000000;
        end
        if (evt_i.overflow && !ovf_en) begin
            res_word = 64'h0000000000000000;
        end
        if (evt_i.op == OP_CONV && conv_fail) begin
            res_word = 64'h0000000000000000;
        end
    end
    // Conversions return an integer, so zero comes from the whole word and sign from conv_int
    assign res_zero = (evt_i.op == OP_CONV) ? (res_word == '0)
        : (res_word[EXP_HI:EXP_LO] == '0);
    assign res_neg = (evt_i.op == OP_CONV) ? (evt_i.conv_int[CONV_W-1] && !conv_fail)
        : (!res_zero && res_word[SIGN_BIT]);

    // Answer to the datapath
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ans_o <= '0;
        end else begin
            ans_o.valid <= evt_i.valid;
            ans_o.abort <= pre_trap;
            ans_o.dbl <= status_q[B_DBL];
            ans_o.long_int <= status_q[B_LONG];
            ans_o.chop <= status_q[B_CHOP];
            if (done) begin
                ans_o.result <= res_word;
            end
            if (evt_i.valid) begin
                ans_o.ac_sel <= from_mem ? (evt_i.ac & AC_MEM_MASK) : evt_i.ac;
                ans_o.step <= status_q[B_DBL] ? STEP_DOUBLE : STEP_SINGLE;
            end
        end
    end

    // Rounding: chop drops the rounding bit, round adds it in
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rnd_frac_o <= '0;
            rnd_valid_o <= 1'b0;
        end else begin
            rnd_valid_o <= rnd_valid_i;
            if (rnd_valid_i) begin
                rnd_frac_o <= (!status_q[B_CHOP] && rnd_bit_i)
                    ? FRAC_W'(rnd_frac_i + 1'b1) : rnd_frac_i;
            end
        end
    end

    // Trap request held until acknowledged; global disable blocks it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            trap_q <= 1'b0;
        end else if (qualify && !status_q[B_TDIS]) begin
            trap_q <= 1'b1;
        end else if (trap_ack_i) begin
            trap_q <= 1'b0;
        end
    end
    assign trap_req_o = trap_q;
    assign trap_vector_o = TRAP_VECTOR;

endmodule // fse_status_exc

// file: testbench/fse_status_exc_properties.sv
// Assertions on the status/exception unit ports.
// Assumes single clock domain, bound onto every fse_status_exc.
`timescale 1ns/1ps
module fse_status_exc_properties
    import fse_pkg::*;
#(
    parameter int FRAC_W = 56
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Host side
    input wire logic trap_ack_i,
    input wire logic trap_req_o,
    input wire logic [15:0] trap_vector_o,
    // Datapath side
    input wire fse_pkg::fse_evt_t evt_i,
    input wire fse_pkg::fse_ans_t ans_o,
    // Rounding
    input wire logic [FRAC_W-1:0] rnd_frac_i,
    input wire logic rnd_bit_i,
    input wire logic rnd_valid_i,
    input wire logic [FRAC_W-1:0] rnd_frac_o,
    input wire logic rnd_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_vec; trap_vector_o == TRAP_VECTOR; endproperty
    a_vec: assert property (p_vec) else $error("trap vector wrong");
    property p_hold; trap_req_o && !trap_ack_i |=> trap_req_o; endproperty
    a_hold: assert property (p_hold) else $error("trap dropped early");
    property p_ack; trap_req_o && trap_ack_i && !evt_i.valid |=> !trap_req_o; endproperty
    a_ack: assert property (p_ack) else $error("trap kept after ack");
    // Trap only ever follows a datapath report
    property p_rise; $rose(trap_req_o) |-> $past(evt_i.valid); endproperty
    a_rise: assert property (p_rise) else $error("trap without event");
    property p_mem;
        evt_i.valid && evt_i.mode != MODE_DIRECT_AC |=> ans_o.valid && ans_o.ac_sel <= 3'h3;
    endproperty
    a_mem: assert property (p_mem) else $error("memory mode accumulator");
    property p_mode0;
        evt_i.valid && evt_i.mode == MODE_DIRECT_AC |=> !ans_o.abort && ans_o.ac_sel == $past(evt_i.ac);
    endproperty
    a_mode0: assert property (p_mode0) else $error("mode 0 handling");
    property p_negabs;
        evt_i.valid && evt_i.phase == PH_OPERAND && evt_i.op inside {OP_NEG, OP_ABS} |=> !ans_o.abort;
    endproperty
    a_negabs: assert property (p_negabs) else $error("early trap on neg/abs");
    property p_step; ans_o.valid |-> ans_o.step == (ans_o.dbl ? STEP_DOUBLE : STEP_SINGLE); endproperty
    a_step: assert property (p_step) else $error("step size wrong");
    property p_rnd;
        rnd_valid_i && !rnd_bit_i |=> rnd_valid_o && rnd_frac_o == $past(rnd_frac_i);
    endproperty
    a_rnd: assert property (p_rnd) else $error("round bit zero changed value");
endmodule // fse_status_exc_properties

bind fse_status_exc fse_status_exc_properties #(.FRAC_W(FRAC_W)) i_fse_props (
    .clk_i(clk_i), .rst_i(rst_i), .trap_ack_i(trap_ack_i), .trap_req_o(trap_req_o),
    .trap_vector_o(trap_vector_o), .evt_i(evt_i), .ans_o(ans_o), .rnd_frac_i(rnd_frac_i),
    .rnd_bit_i(rnd_bit_i), .rnd_valid_i(rnd_valid_i), .rnd_frac_o(rnd_frac_o),
    .rnd_valid_o(rnd_valid_o));

// file: testbench/fse_host_model.sv
// Host processor model: takes the shared trap and acknowledges it.
// Assumes one clock; slow_i stretches the acknowledge delay.
`timescale 1ns/1ps
module fse_host_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Trap interface
    input wire logic trap_req_i,
    input wire logic [15:0] trap_vector_i,
    input wire logic slow_i,
    output logic trap_ack_o,
    output logic [7:0] trap_cnt_o
);
    logic [3:0] wait_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_q <= 4'h0;
            trap_ack_o <= 1'b0;
            trap_cnt_o <= 8'h00;
        end else if (trap_ack_o) begin
            trap_ack_o <= 1'b0;
        end else if (trap_req_i && wait_q == (slow_i ? 4'h6 : 4'h0)) begin
            // Only traps through the shared slot are counted
            trap_ack_o <= 1'b1;
            trap_cnt_o <= trap_cnt_o + ((trap_vector_i == 16'h00A4) ? 8'h01 : 8'h00);
            wait_q <= 4'h0;
        end else if (trap_req_i) begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule // fse_host_model

// file: testbench/fpu_status_exception_unit_bench.sv
// Self-checking bench for the status/exception unit.
// Assumes the host model acks traps; registers over Avalon-MM.
`timescale 1ns/1ps
module fpu_status_exception_unit_bench;
    import fse_pkg::*;
    logic clk_i = 0, rst_i = 1, re = 0, we = 0, kern = 0, slow = 0, rv = 0, rb = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, rdat, v;
    logic [55:0] rf = 56'h0, rfo;
    logic wq, ack, req, rvo;
    logic [15:0] vec;
    logic [7:0] traps, t0;
    fse_evt_t evt = '0, e;
    fse_ans_t ans;
    int fail_count = 0, check_count = 0;
    always #5 clk_i = ~clk_i;
    fse_status_exc i_fse_status_exc (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
        .avs_read_i(re), .avs_write_i(we), .avs_writedata_i(wd), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wq), .cpu_kernel_i(kern), .trap_ack_i(ack), .trap_req_o(req),
        .trap_vector_o(vec), .evt_i(evt), .ans_o(ans), .rnd_frac_i(rf), .rnd_bit_i(rb),
        .rnd_valid_i(rv), .rnd_frac_o(rfo), .rnd_valid_o(rvo));
    fse_host_model i_fse_host_model (.clk_i(clk_i), .rst_i(rst_i), .trap_req_i(req),
        .trap_vector_i(vec), .slow_i(slow), .trap_ack_o(ack), .trap_cnt_o(traps));
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [63:0] g, input logic [63:0] x);
        check_count++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    // One Avalon access; read data lands in v
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        adr <= a;
        wd <= {16'h0, d};
        we <= w;
        re <= !w;
        do @(posedge clk_i); while (wq !== 1'b0);
        v = rdat;
        we <= 0;
        re <= 0;
    endtask
    task automatic ev(input fse_phase_t ph);
        e.valid = 1;
        e.phase = ph;
        @(posedge clk_i);
        evt <= e;
        @(posedge clk_i);
        evt.valid <= 0;
        @(negedge clk_i);
    endtask
    task automatic rnd(input logic [55:0] x);
        @(posedge clk_i);
        rf <= 56'h5;
        rb <= 1;
        rv <= 1;
        @(posedge clk_i);
        rv <= 0;
        @(negedge clk_i);
        chk(rvo, 1);
        chk(rfo, x);
    endtask
    initial begin
        #200000;
        fail_count++;
        stop_test;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        acc(0, ADDR_STATUS, 0);
        chk(v, STATUS_RST);
        acc(1, ADDR_STATUS, 16'hFFFF);
        acc(0, ADDR_STATUS, 0);
        chk(v, 32'hCFEF);
        kern <= 1;
        acc(1, ADDR_STATUS, 16'h0010);
        acc(0, ADDR_STATUS, 0);
        chk(v, 32'h0010);
        acc(1, ADDR_CODE, 16'h000F);
        acc(0, ADDR_CODE, 0);
        chk(v, 0);
        acc(0, 4'hC, 0);
        chk(v, 0);
        // Enabled overflow, slow host
        slow <= 1;
        acc(1, ADDR_STATUS, 16'h0200);
        e = '0;
        e.op = OP_ADD;
        e.mode = 3'h1;
        e.instr_addr = 16'h1234;
        e.overflow = 1;
        e.result = 64'h4080000000000000;
        t0 = traps;
        ev(PH_DONE);
        chk(ans.result, e.result);
        repeat (3) @(posedge clk_i);
        chk(req, 1);
        repeat (8) @(posedge clk_i);
        chk(req, 0);
        chk(traps, t0 + 8'h01);
        slow <= 0;
        acc(0, ADDR_CODE, 0);
        chk(v, EC_OVF);
        acc(0, ADDR_ADDR, 0);
        chk(v, 32'h1234);
        acc(0, ADDR_STATUS, 0);
        chk(v, 32'h8202);
        // Disabled overflow and underflow give exact zero
        acc(1, ADDR_STATUS, 16'h0000);
        e.instr_addr = 16'h2222;
        ev(PH_DONE);
        chk(ans.result, 0);
        chk(req, 0);
        acc(0, ADDR_STATUS, 0);
        chk(v, 32'h0006);
        acc(0, ADDR_ADDR, 0);
        chk(v, 32'h1234);
        e.overflow = 0;
        e.underflow = 1;
        ev(PH_DONE);
        chk(ans.result, 0);
        // Global disable: record but no trap
        acc(1, ADDR_STATUS, 16'h4400);
        ev(PH_DONE);
        chk(req, 0);
        acc(0, ADDR_CODE, 0);
        chk(v, EC_UNF);
        // Undefined operand from memory
        acc(1, ADDR_STATUS, 16'h0800);
        e = '0;
        e.mode = 3'h1;
        e.op_sign = 1;
        e.instr_addr = 16'h4444;
        for (int k = 0; k < 10; k++) begin
            e.op = fse_op_t'(k);
            if (k != 6 && k != 7) begin
                ev(PH_OPERAND);
                chk(ans.abort, 1);
            end
        end
        acc(0, ADDR_CODE, 0);
        chk(v, EC_UNDEF);
        e.op = OP_NEG;
        repeat (3) @(posedge clk_i);
        ev(PH_OPERAND);
        chk({ans.abort, req}, 0);
        ev(PH_DONE);
        chk(req, 1);
        e.mode = MODE_DIRECT_AC;
        e.ac = 3'h5;
        e.op = OP_ADD;
        ev(PH_OPERAND);
        chk({ans.abort, ans.ac_sel}, 4'h5);
        // Conversion out of short range, then long
        acc(1, ADDR_STATUS, 16'h0180);
        e = '0;
        e.op = OP_CONV;
        e.conv_int = 40'sd40000;
        e.result = 64'h9C40;
        ev(PH_DONE);
        chk(ans.result, 64'h0);
        chk(ans.step, STEP_DOUBLE);
        acc(0, ADDR_CODE, 0);
        chk(v, EC_ICONV);
        acc(1, ADDR_STATUS, 16'h0140);
        ev(PH_DONE);
        chk(ans.result, 64'h9C40);
        rnd(56'h6);
        acc(1, ADDR_STATUS, 16'h0020);
        rnd(56'h5);
        // Mode copies, negative and carry flags
        acc(1, ADDR_STATUS, 16'h00E0);
        e = '0;
        e.op = OP_ADD;
        e.mode = 3'h1;
        e.result = 64'hC080000000000000;
        ev(PH_DONE);
        chk({ans.dbl, ans.long_int, ans.chop}, 3'h7);
        acc(0, ADDR_STATUS, 0);
        chk(v, 32'h00E8);
        e.op = OP_CONV;
        e.carry = 1;
        e.conv_int = -40'sd5;
        e.result = 64'hFFFFFFFB;
        ev(PH_DONE);
        acc(0, ADDR_STATUS, 0);
        chk(v, 32'h00E9);
        // Divide by zero and opcode causes with enables clear, then maintenance with maintenance bit set
        acc(1, ADDR_STATUS, 16'h0000);
        e = '0;
        e.op = OP_DIV;
        e.mode = 3'h1;
        e.op_sign = 1;
        e.instr_addr = 16'h5555;
        ev(PH_OPERAND);
        chk(ans.abort, 0);
        e.div_zero = 1;
        ev(PH_DONE);
        chk(req, 1);
        acc(0, ADDR_CODE, 0);
        chk(v, EC_DIV0);
        acc(0, ADDR_STATUS, 0);
        chk(v, 32'h8004);
        e.div_zero = 0;
        e.illegal_op = 1;
        ev(PH_DONE);
        acc(0, ADDR_CODE, 0);
        chk(v, EC_OPCODE);
        acc(1, ADDR_STATUS, 16'h0010);
        e.illegal_op = 0;
        e.maint_trap = 1;
        ev(PH_DONE);
        acc(0, ADDR_CODE, 0);
        chk(v, EC_MAINT);
        stop_test;
    end
endmodule // fpu_status_exception_unit_bench
